/* File: hw/led_diag_regs.sv */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Per-colour fine low-gray enables, reset off
// - Per-colour turn-off slew bit, reset slow
// - Per-colour two-bit turn-on slew, reset 01
// - Per-colour coarse low-gray enables, reset off
// - Four-bit first-line dim, reset 0000
// - On/off isolation enable, reset off
// - Four-bit isolation boost level, reset 1000
// - Isolation boost enable, reset off
// - Open-fault line index stored and returned
// - Short-fault line index stored and returned
// - Open warning bitmap per line, upper zero
// - Short warning bitmap per line, upper zero
// - Open channel bitmap, 48 bits
// - Short channel bitmap, 48 bits
// - Writes on serial in, reads on out
// - Fault readback only when enable set
module led_diag_regs
    import led_diag_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 arst_n,
    // Link pins, asynchronous to clock
    input  wire logic                 serial_clk,
    input  wire logic                 serial_in_pin,
    output logic                      serial_out_pin,
    // Readback gate and detector results, same clock domain
    input  wire logic                 fault_readback_en,
    input  wire logic                 det_valid,
    input  wire logic [4:0]           det_line,
    input  wire logic [CHANNELS-1:0]  det_open,
    input  wire logic [CHANNELS-1:0]  det_short,
    // Configuration fields and fault views
    output logic [2:0]                lowgray_fine_en,
    output logic [2:0]                turnoff_slew,
    output logic [1:0]                red_turnon_slew,
    output logic [1:0]                green_turnon_slew,
    output logic [1:0]                blue_turnon_slew,
    output logic [2:0]                lowgray_coarse_en,
    output logic [3:0]                first_line_dim,
    output logic                      on_off_isolation_en,
    output logic [3:0]                isolation_boost_level,
    output logic                      isolation_boost_en,
    output logic [4:0]                open_fault_line_index,
    output logic [4:0]                short_fault_line_index,
    output logic [LINES-1:0]          open_fault_line_map,
    output logic [LINES-1:0]          short_fault_line_map,
    output logic [CHANNELS-1:0]       open_fault_channel_map,
    output logic [CHANNELS-1:0]       short_fault_channel_map
);

    // Two-flop synchronisers; third sclk flop only feeds edge detect
    logic                 sclk_s1;
    logic                 sclk_s2;
    logic                 sclk_s3;
    logic                 sin_s1;
    logic                 sin_s2;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
        end else begin
            sclk_s1 <= serial_clk;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
        end
    end

    // Same depth as the clock path, so data and edge stay aligned
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sin_s1 <= 1'b0;
            sin_s2 <= 1'b0;
        end else begin
            sin_s1 <= serial_in_pin;
            sin_s2 <= sin_s1;
        end
    end

    wire sclk_rise = sclk_s2 & ~sclk_s3;
    wire sclk_fall = ~sclk_s2 & sclk_s3;

    // Fault result storage, one word per scan line
    logic [CHANNELS-1:0]  open_mem  [LINES];
    logic [CHANNELS-1:0]  short_mem [LINES];

    always_ff @(posedge clock) begin
        if (det_valid) begin
            open_mem[det_line]  <= det_open;
            short_mem[det_line] <= det_short;
        end
    end

    // Line maps also mark which memory words were last written with a nonzero fault word
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            open_fault_line_map <= '0;
        end else if (det_valid) begin
            open_fault_line_map[det_line] <= |det_open;
        end
    end

    // A clean report clears the bit, so the map is a live view
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            short_fault_line_map <= '0;
        end else if (det_valid) begin
            short_fault_line_map[det_line] <= |det_short;
        end
    end

    // Unwritten lines read zero rather than stale memory
    wire [CHANNELS-1:0] open_sel  = open_fault_line_map[open_fault_line_index]
                                    ? open_mem[open_fault_line_index] : '0;
    wire [CHANNELS-1:0] short_sel = short_fault_line_map[short_fault_line_index]
                                    ? short_mem[short_fault_line_index] : '0;

    // Registered views lag an index write by one clock
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            open_fault_channel_map <= '0;
        end else begin
            open_fault_channel_map <= open_sel;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            short_fault_channel_map <= '0;
        end else begin
            short_fault_channel_map <= short_sel;
        end
    end

    // Serial link state
    link_state_t          state;
    logic [5:0]           bit_cnt;
    logic [HDR_BITS-1:0]  header;
    logic [WORD_BITS-1:0] shift;

    wire                  hdr_read  = header[3];
    wire [3:0]            hdr_addr  = {header[2:0], sin_s2};
    wire                  hdr_done  = (state == ST_HEADER) && sclk_rise
                                      && (bit_cnt == CNT_HDR_LAST);
    wire                  word_last = (bit_cnt == CNT_WORD_LAST);
    wire                  wr_commit = (state == ST_WRITE) && sclk_rise && word_last;
    wire [WORD_BITS-1:0]  wr_word   = {shift[WORD_BITS-2:0], sin_s2};
    logic [3:0]           wr_addr;

    // Read value assembly; reserved bits read zero
    wire [WORD_BITS-1:0] tuning_word = {
        3'h0, isolation_boost_en, isolation_boost_level, on_off_isolation_en,
        first_line_dim, lowgray_coarse_en, 4'h0, blue_turnon_slew,
        green_turnon_slew, red_turnon_slew, turnoff_slew, lowgray_fine_en, 16'h0000};
    wire [WORD_BITS-1:0] open_idx_word  = {43'h0, open_fault_line_index};
    wire [WORD_BITS-1:0] short_idx_word = {43'h0, short_fault_line_index};
    wire                 rb             = fault_readback_en;
    wire [WORD_BITS-1:0] open_map_word  = rb ? {16'h0000, open_fault_line_map} : '0;
    wire [WORD_BITS-1:0] short_map_word = rb ? {16'h0000, short_fault_line_map} : '0;
    wire [WORD_BITS-1:0] open_ch_word   = rb ? open_fault_channel_map : '0;
    wire [WORD_BITS-1:0] short_ch_word  = rb ? short_fault_channel_map : '0;

    // Unknown register numbers read zero; no error is flagged
    function automatic logic [WORD_BITS-1:0] read_value(
        input logic [3:0] num
    );
        if (num == REG_TUNING_FOUR) begin
            read_value = tuning_word;
        end else if (num == REG_OPEN_LINE_SEL) begin
            read_value = open_idx_word;
        end else if (num == REG_SHORT_LINE_SEL) begin
            read_value = short_idx_word;
        end else if (num == REG_OPEN_LINE_MAP) begin
            read_value = open_map_word;
        end else if (num == REG_SHORT_LINE_MAP) begin
            read_value = short_map_word;
        end else if (num == REG_OPEN_CH_MAP) begin
            read_value = open_ch_word;
        end else if (num == REG_SHORT_CH_MAP) begin
            read_value = short_ch_word;
        end else begin
            read_value = '0;
        end
    endfunction

    wire [WORD_BITS-1:0] rd_word = read_value(hdr_addr);

    // Frame: start 1, read flag, 4-bit register, 48 data bits MSB first
    link_state_t          next_state;
    logic [5:0]           next_bit_cnt;
    logic [HDR_BITS-1:0]  next_header;
    logic [WORD_BITS-1:0] next_shift;
    logic [3:0]           next_wr_addr;

    always_comb begin
        next_state   = state;
        next_bit_cnt = bit_cnt;
        next_header  = header;
        next_shift   = shift;
        next_wr_addr = wr_addr;
        case (state)
            ST_IDLE: begin
                if (sclk_rise && sin_s2) begin
                    next_state   = ST_HEADER;
                    next_bit_cnt = '0;
                end
            end
            ST_HEADER: begin
                if (sclk_rise) begin
                    next_header  = {header[HDR_BITS-2:0], sin_s2};
                    next_bit_cnt = bit_cnt + 6'h01;
                end
                if (hdr_done) begin
                    next_bit_cnt = '0;
                    next_wr_addr = hdr_addr;
                    if (hdr_read) begin
                        next_state = ST_READ;
                        next_shift = rd_word;
                    end else begin
                        next_state = ST_WRITE;
                    end
                end
            end
            ST_WRITE: begin
                if (sclk_rise) begin
                    next_shift   = wr_word;
                    next_bit_cnt = bit_cnt + 6'h01;
                    if (word_last) begin
                        next_state = ST_IDLE;
                    end
                end
            end
            ST_READ: begin
                // Shift on the falling edge so the bit stands over the rising one
                if (sclk_fall) begin
                    next_shift   = {shift[WORD_BITS-2:0], 1'b0};
                    next_bit_cnt = bit_cnt + 6'h01;
                    if (word_last) begin
                        next_state = ST_IDLE;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state   <= ST_IDLE;
            bit_cnt <= '0;
            header  <= '0;
            shift   <= '0;
            wr_addr <= '0;
        end else begin
            state   <= next_state;
            bit_cnt <= next_bit_cnt;
            header  <= next_header;
            shift   <= next_shift;
            wr_addr <= next_wr_addr;
        end
    end

    // Output held low outside read frames
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            serial_out_pin <= 1'b0;
        end else begin
            serial_out_pin <= (state == ST_READ) ? shift[WORD_BITS-1] : 1'b0;
        end
    end

    wire wr_tuning = wr_commit && (wr_addr == REG_TUNING_FOUR);
    wire wr_open   = wr_commit && (wr_addr == REG_OPEN_LINE_SEL);
    wire wr_short  = wr_commit && (wr_addr == REG_SHORT_LINE_SEL);

    // Writes to read-only registers and reserved bits are dropped
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            lowgray_fine_en       <= RST_FINE;
            turnoff_slew          <= RST_OFF_SLEW;
            red_turnon_slew       <= RST_ON_SLEW;
            green_turnon_slew     <= RST_ON_SLEW;
            blue_turnon_slew      <= RST_ON_SLEW;
            lowgray_coarse_en     <= RST_COARSE;
            first_line_dim        <= RST_DIM;
            on_off_isolation_en   <= RST_ISO;
            isolation_boost_level <= RST_BOOST_LVL;
            isolation_boost_en    <= RST_BOOST_EN;
        end else if (wr_tuning) begin
            lowgray_fine_en       <= wr_word[POS_FINE +: 3];
            turnoff_slew          <= wr_word[POS_OFF_SLEW +: 3];
            red_turnon_slew       <= wr_word[POS_ON_SLEW_R +: 2];
            green_turnon_slew     <= wr_word[POS_ON_SLEW_G +: 2];
            blue_turnon_slew      <= wr_word[POS_ON_SLEW_B +: 2];
            lowgray_coarse_en     <= wr_word[POS_COARSE +: 3];
            first_line_dim        <= wr_word[POS_DIM +: 4];
            on_off_isolation_en   <= wr_word[POS_ISO];
            isolation_boost_level <= wr_word[POS_BOOST_LVL +: 4];
            isolation_boost_en    <= wr_word[POS_BOOST_EN];
        end
    end

    // Upper bits of an index write are reserved and dropped
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            open_fault_line_index <= RST_LINE_IDX;
        end else if (wr_open) begin
            open_fault_line_index <= wr_word[POS_LINE_IDX +: 5];
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            short_fault_line_index <= RST_LINE_IDX;
        end else if (wr_short) begin
            short_fault_line_index <= wr_word[POS_LINE_IDX +: 5];
        end
    end

endmodule

`default_nettype wire

/* File: hw/led_diag_pkg.sv */
package led_diag_pkg;

    // Register numbers carried in the serial header
    localparam logic [3:0]  REG_TUNING_FOUR    = 4'h4;
    localparam logic [3:0]  REG_OPEN_LINE_SEL  = 4'hA;
    localparam logic [3:0]  REG_SHORT_LINE_SEL = 4'hB;
    localparam logic [3:0]  REG_OPEN_LINE_MAP  = 4'hC;
    localparam logic [3:0]  REG_SHORT_LINE_MAP = 4'hD;
    localparam logic [3:0]  REG_OPEN_CH_MAP    = 4'hE;
    localparam logic [3:0]  REG_SHORT_CH_MAP   = 4'hF;

    localparam int          WORD_BITS          = 48;
    localparam int          HDR_BITS           = 5;
    localparam int          LINES              = 32;
    localparam int          CHANNELS           = 48;

    // Field positions of the tuning word
    localparam int          POS_FINE           = 16;
    localparam int          POS_OFF_SLEW       = 19;
    localparam int          POS_ON_SLEW_R      = 22;
    localparam int          POS_ON_SLEW_G      = 24;
    localparam int          POS_ON_SLEW_B      = 26;
    localparam int          POS_COARSE         = 32;
    localparam int          POS_DIM            = 35;
    localparam int          POS_ISO            = 39;
    localparam int          POS_BOOST_LVL      = 40;
    localparam int          POS_BOOST_EN       = 44;
    localparam int          POS_LINE_IDX       = 0;

    // Values after reset
    localparam logic [2:0]  RST_FINE           = 3'h0;
    localparam logic [2:0]  RST_OFF_SLEW       = 3'h0;
    localparam logic [1:0]  RST_ON_SLEW        = 2'h1;
    localparam logic [2:0]  RST_COARSE         = 3'h0;
    localparam logic [3:0]  RST_DIM            = 4'h0;
    localparam logic        RST_ISO            = 1'b0;
    localparam logic [3:0]  RST_BOOST_LVL      = 4'h8;
    localparam logic        RST_BOOST_EN       = 1'b0;
    localparam logic [4:0]  RST_LINE_IDX       = 5'h00;

    localparam logic [5:0]  CNT_HDR_LAST       = 6'h04;
    localparam logic [5:0]  CNT_WORD_LAST      = 6'h2F;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_HEADER = 2'b01,
        ST_WRITE  = 2'b10,
        ST_READ   = 2'b11
    } link_state_t;

endpackage

/* File: dv/led_diag_regs_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module led_diag_regs_assertions
    import led_diag_pkg::*;
(
    input wire logic                clock,
    input wire logic                arst_n,
    input wire logic                serial_in_pin,
    input wire logic                serial_out_pin,
    input wire logic                det_valid,
    input wire logic [4:0]          det_line,
    input wire logic [CHANNELS-1:0] det_open,
    input wire logic [CHANNELS-1:0] det_short,
    input wire logic [1:0]          red_turnon_slew,
    input wire logic [3:0]          isolation_boost_level,
    input wire logic [4:0]          open_fault_line_index,
    input wire logic [4:0]          short_fault_line_index,
    input wire logic [LINES-1:0]    open_fault_line_map,
    input wire logic [LINES-1:0]    short_fault_line_map,
    input wire logic [CHANNELS-1:0] open_fault_channel_map,
    input wire logic [CHANNELS-1:0] short_fault_channel_map
);
    // Longer than a whole frame with readout, so nothing can be in flight
    localparam int QUIET = 800;
    logic [9:0] quiet_cnt;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            quiet_cnt <= 10'h000;
        end else if (serial_in_pin) begin
            quiet_cnt <= 10'h000;
        end else if (quiet_cnt != 10'h3FF) begin
            quiet_cnt <= quiet_cnt + 10'h001;
        end
    end
    sequence open_hit; det_valid && det_line == open_fault_line_index; endsequence
    sequence short_hit; det_valid && det_line == short_fault_line_index; endsequence
    AST_RESET_VALUES: assert property ($rose(arst_n) |-> red_turnon_slew == 2'h1
        && isolation_boost_level == 4'h8 && open_fault_line_index == 5'h00
        && short_fault_line_index == 5'h00) else $error("reset values wrong");
    AST_QUIET_BUS: assert property (quiet_cnt >= QUIET |-> serial_out_pin == 1'b0
        && $stable(isolation_boost_level) && $stable(red_turnon_slew))
        else $error("activity on an idle link");
    AST_OPEN_LINE_MAP: assert property (det_valid |=>
        open_fault_line_map[$past(det_line)] == (|$past(det_open))) else $error("open line bit");
    AST_SHORT_LINE_MAP: assert property (det_valid |=>
        short_fault_line_map[$past(det_line)] == (|$past(det_short))) else $error("short line bit");
    AST_OPEN_LINE_HOLD: assert property (!det_valid |=> $stable(open_fault_line_map))
        else $error("open line map moved");
    AST_SHORT_LINE_HOLD: assert property (!det_valid |=> $stable(short_fault_line_map))
        else $error("short line map moved");
    AST_OPEN_CH_FOLLOW: assert property (open_hit ##1 $stable(open_fault_line_index) |=>
        open_fault_channel_map == $past(det_open, 2)) else $error("open channel map");
    AST_SHORT_CH_FOLLOW: assert property (short_hit ##1 $stable(short_fault_line_index) |=>
        short_fault_channel_map == $past(det_short, 2)) else $error("short channel map");
endmodule
bind led_diag_regs led_diag_regs_assertions u_chk (.clock, .arst_n, .serial_in_pin,
    .serial_out_pin, .det_valid, .det_line, .det_open, .det_short, .red_turnon_slew,
    .isolation_boost_level, .open_fault_line_index, .short_fault_line_index,
    .open_fault_line_map, .short_fault_line_map, .open_fault_channel_map,
    .short_fault_channel_map);
`default_nettype wire

/* File: dv/serial_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_ctrl_model (
    output logic      serial_clk,
    output logic      serial_in_pin,
    input  wire logic serial_out_pin
);
    // Link clock is continuous, so it keeps running between frames
    initial begin
        serial_clk = 1'b0;
        serial_in_pin = 1'b0;
        forever #62.5 serial_clk = ~serial_clk;
    end
    // Data moves on falling edges, half a bit away from the sampling edge
    task automatic send_bits(input logic [53:0] bits, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(negedge serial_clk) #1 serial_in_pin = bits[i];
        end
    endtask
    task automatic write_reg(input logic [3:0] num, input logic [47:0] data);
        send_bits({2'b10, num, data}, 54);
        @(negedge serial_clk) #1 serial_in_pin = 1'b0;
        repeat (2) @(negedge serial_clk);
    endtask
    task automatic read_reg(input logic [3:0] num, output logic [47:0] data);
        send_bits({48'h0, 2'b11, num}, 6);
        for (int i = 47; i >= 0; i--) begin
            @(negedge serial_clk) data[i] = serial_out_pin;
            #1 serial_in_pin = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import led_diag_pkg::*;
    logic        clock, arst_n, serial_clk, serial_in_pin, serial_out_pin, fault_readback_en;
    logic        det_valid, on_off_isolation_en, isolation_boost_en;
    logic [4:0]  det_line, open_fault_line_index, short_fault_line_index;
    logic [47:0] det_open, det_short, open_fault_channel_map, short_fault_channel_map;
    logic [31:0] open_fault_line_map, short_fault_line_map;
    logic [2:0]  lowgray_fine_en, turnoff_slew, lowgray_coarse_en;
    logic [1:0]  red_turnon_slew, green_turnon_slew, blue_turnon_slew;
    logic [3:0]  first_line_dim, isolation_boost_level;
    logic [47:0] rd_word, wr_word, tuning_ports;
    int          err_count, n_compared;
    localparam logic [47:0] RW_MASK = 48'h1FFF_0FFF_0000;
    assign tuning_ports = {3'h0, isolation_boost_en, isolation_boost_level, on_off_isolation_en,
        first_line_dim, lowgray_coarse_en, 4'h0, blue_turnon_slew, green_turnon_slew,
        red_turnon_slew, turnoff_slew, lowgray_fine_en, 16'h0};
    led_diag_regs DUT (.*);
    serial_ctrl_model ctrl (.*);
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [3:0] num, input logic [47:0] exp);
        ctrl.read_reg(num, rd_word);
        check(rd_word, exp);
    endtask
    task automatic report_det(input logic [4:0] ln, input logic [47:0] op, input logic [47:0] sh);
        @(posedge clock) #1 det_valid = 1'b1;
        det_line = ln;
        det_open = op;
        det_short = sh;
        @(posedge clock) #1 det_valid = 1'b0;
        repeat (3) @(posedge clock);
    endtask
    task automatic report_and_stop();
        if (err_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #500us err_count++;
        report_and_stop();
    end
    initial begin
        arst_n = 1'b0;
        fault_readback_en = 1'b0;
        det_valid = 1'b0;
        det_line = 5'h00;
        det_open = 48'h0;
        det_short = 48'h0;
        repeat (5) @(posedge clock);
        #1 arst_n = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        check(tuning_ports, 48'h0800_0540_0000);
        check({38'h0, open_fault_line_index, short_fault_line_index}, 48'h0);
        rdchk(REG_TUNING_FOUR, 48'h0800_0540_0000);
        // Nibbles 0,5,A,F put every turn-on slew code in every colour
        for (int k = 0; k < 4; k++) begin
            wr_word = {12{4'(k * 5)}};
            ctrl.write_reg(REG_TUNING_FOUR, wr_word);
            check(tuning_ports, wr_word & RW_MASK);
            rdchk(REG_TUNING_FOUR, wr_word & RW_MASK);
        end
        ctrl.write_reg(REG_OPEN_LINE_SEL, 48'hFFFF_FFFF_FFFF);
        rdchk(REG_OPEN_LINE_SEL, 48'h1F);
        ctrl.write_reg(REG_SHORT_LINE_SEL, 48'h3);
        rdchk(REG_SHORT_LINE_SEL, 48'h3);
        check({38'h0, open_fault_line_index, short_fault_line_index}, 48'h3E3);
        report_det(5'h1F, 48'h8000_0000_0001, 48'h0);
        report_det(5'h03, 48'h0, 48'h0000_0000_0F00);
        check(open_fault_channel_map, 48'h8000_0000_0001);
        check(short_fault_channel_map, 48'h0F00);
        rdchk(REG_OPEN_CH_MAP, 48'h0);
        rdchk(REG_SHORT_LINE_MAP, 48'h0);
        @(posedge clock) #1 fault_readback_en = 1'b1;
        ctrl.write_reg(REG_OPEN_LINE_MAP, 48'hFFFF_FFFF_FFFF);
        rdchk(REG_OPEN_LINE_MAP, 48'h8000_0000);
        rdchk(REG_SHORT_LINE_MAP, 48'h8);
        rdchk(REG_OPEN_CH_MAP, 48'h8000_0000_0001);
        rdchk(REG_SHORT_CH_MAP, 48'h0F00);
        rdchk(4'h5, 48'h0);
        report_det(5'h1F, 48'h0, 48'h0);
        #1;
        check({16'h0000, open_fault_line_map}, 48'h0);
        check(open_fault_channel_map, 48'h0);
        repeat (900) @(posedge clock);
        report_and_stop();
    end
endmodule
`default_nettype wire
